// [src/pti_map.svh]
// register map, field positions and reset values of the pressure threshold core
// assumes: included by bare name from every design file that needs a constant
// Function
// - registers selected by seven-bit address
// - threshold function active when either enable set
// - compare differential pressure with 15-bit threshold
// - threshold split low/high bytes, reset zero
// - high/low enables request interrupt above/below
// - latch request holds interrupt in source register
// - subtract mode captures reference, subtracts everywhere
// - subtract enable self-clears after first conversion
// - subtract reset returns normal, clears reference
// - irq-only mode captures reference, output unmodified
// - irq-only enable self-clears after first conversion, after second if subtract also pending
// - interrupt pin output under I3C when enabled
// - two-wire bus disable turns off I2C/I3C
// - SPI four-wire at zero, three-wire at one
// - pull enables connect, pull disables disconnect
`ifndef PTI_MAP_SVH
`define PTI_MAP_SVH

// widths
`define PTI_ADDR_W 7
`define PTI_DATA_W 8
`define PTI_PRESS_W 24
`define PTI_REF_W 16
`define PTI_THS_W 15
`define PTI_DIFF_W 17

// register addresses
`define PTI_ADDR_IRQ_CFG 7'h0B
`define PTI_ADDR_THS_LOW 7'h0C
`define PTI_ADDR_THS_HIGH 7'h0D
`define PTI_ADDR_IF_CTRL 7'h0E
`define PTI_ADDR_IDENT 7'h0F
`define PTI_ADDR_CTRL_ONE 7'h10
`define PTI_ADDR_REF_LOW 7'h16
`define PTI_ADDR_REF_HIGH 7'h17
`define PTI_ADDR_IRQ_SRC 7'h24
`define PTI_ADDR_OUT_XL 7'h28
`define PTI_ADDR_OUT_L 7'h29
`define PTI_ADDR_OUT_H 7'h2A

// threshold_irq_config fields
`define PTI_CFG_IRQREF_EN 7
`define PTI_CFG_IRQREF_RST 6
`define PTI_CFG_SUBREF_EN 5
`define PTI_CFG_SUBREF_RST 4
`define PTI_CFG_LATCH 2
`define PTI_CFG_LOW_EN 1
`define PTI_CFG_HIGH_EN 0

// interface_control fields
`define PTI_IF_IRQ_I3C 7
`define PTI_IF_BUS_DIS 6
`define PTI_IF_SPI_SEL 5
`define PTI_IF_SDA_PU 4
`define PTI_IF_SDO_PU 3
`define PTI_IF_IRQ_PIN_PULLDOWN_DISABLE 2
`define PTI_IF_SELECT_PIN_PULLUP_DISABLE 1

// interrupt source fields
`define PTI_SRC_HIGH 0
`define PTI_SRC_LOW 1
`define PTI_SRC_ACTIVE 2

// reset values
`define PTI_RST_BYTE 8'h00
`define PTI_RST_REF 16'h0000
`define PTI_RST_PRESS 24'h000000
`define PTI_RST_SRC 3'h0
`define PTI_RST_CTRL 7'h00
// identification value: arbitrary, names no part
`define PTI_IDENT_VAL 8'h5A

`endif

// [src/pti_pkg.sv]
// types shared by the pressure threshold core
// assumes: compiled before every module of the core
package pti_pkg;
   // reference handling mode of the differential path
   typedef enum logic [1:0] {
      PTI_MODE_NORMAL,
      PTI_MODE_SUBTRACT,
      PTI_MODE_IRQ_ONLY
   } pti_mode_t;
endpackage

// [src/pti_refcalc.sv]
// differential pressure arithmetic: compare value and reported output pressure
// assumes: measured sample and reference are stable while the caller samples them
`timescale 1ns/1ps
`include "pti_map.svh"
module pti_refcalc
   import pti_pkg::*;
(
   input wire logic [`PTI_PRESS_W-1:0] meas_in,
   input wire logic [`PTI_REF_W-1:0] ref_in,
   input wire pti_mode_t mode_in,
   output logic signed [`PTI_DIFF_W-1:0] diff_out,
   output logic [`PTI_PRESS_W-1:0] output_pressure
);
   // reference only counts outside normal mode
   wire logic use_ref = (mode_in != PTI_MODE_NORMAL);
   wire logic [`PTI_REF_W-1:0] eff_ref = use_ref ? ref_in : `PTI_RST_REF;
   // upper sixteen bits share the threshold scale of 1/16 hPa
   wire logic [`PTI_REF_W-1:0] meas_hi = meas_in[`PTI_PRESS_W-1:`PTI_PRESS_W-`PTI_REF_W];
   // widen by one bit so the difference keeps its sign
   assign diff_out = $signed({1'b0, meas_hi}) - $signed({1'b0, eff_ref});
   // reference only subtracted from output in subtract mode
   wire logic [`PTI_PRESS_W-1:0] ref_full = {ref_in, 8'h00};
   assign output_pressure = (mode_in == PTI_MODE_SUBTRACT) ?
                      meas_in - ref_full : meas_in;
endmodule

// [src/pti_pinctl.sv]
// pin and interface steering decoded from interface_control
// assumes: i3c_active_in comes from the bus engine on the same clock
`timescale 1ns/1ps
`include "pti_map.svh"
module pti_pinctl (
   input wire logic [`PTI_DATA_W-1:0] if_ctrl_in,
   input wire logic i3c_active_in,
   input wire logic irq_level_in,
   output logic irq_pin_data_out,
   output logic irq_pin_oe_n_out,
   output logic two_wire_enable_out,
   output logic spi_three_wire_out,
   output logic data_line_pullup_out,
   output logic serial_out_pullup_out,
   output logic irq_pin_pulldown_out,
   output logic select_pin_pullup_out
);
   // under I3C the pin drives only when allowed; otherwise it always drives
   wire logic pin_drive = !i3c_active_in || if_ctrl_in[`PTI_IF_IRQ_I3C];
   assign irq_pin_oe_n_out = !pin_drive;
   assign irq_pin_data_out = irq_level_in;
   // two-wire engines idle when disabled
   assign two_wire_enable_out = !if_ctrl_in[`PTI_IF_BUS_DIS];
   assign spi_three_wire_out = if_ctrl_in[`PTI_IF_SPI_SEL];
   // enables connect, disables disconnect
   assign data_line_pullup_out = if_ctrl_in[`PTI_IF_SDA_PU];
   assign serial_out_pullup_out = if_ctrl_in[`PTI_IF_SDO_PU];
   assign irq_pin_pulldown_out = !if_ctrl_in[`PTI_IF_IRQ_PIN_PULLDOWN_DISABLE];
   assign select_pin_pullup_out = !if_ctrl_in[`PTI_IF_SELECT_PIN_PULLUP_DISABLE];
endmodule

// [src/pti_regs.sv]
// register bank and threshold event logic of the pressure core
// assumes: the serial engine hands over decoded accesses on the same clock;
// conversions arrive as a one-cycle strobe with the measured sample beside it
`timescale 1ns/1ps
`include "pti_map.svh"
module pti_regs
   import pti_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   // register access from the serial engine
   input wire logic [`PTI_ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [`PTI_DATA_W-1:0] reg_wdata_in,
   output logic [`PTI_DATA_W-1:0] reg_rdata_out,
   // conversion results
   input wire logic conv_done_in,
   input wire logic [`PTI_PRESS_W-1:0] meas_pressure_in,
   // bus state
   input wire logic i3c_active_in,
   // event and pin outputs
   output logic threshold_irq_out,
   output logic [`PTI_PRESS_W-1:0] output_pressure_out,
   output logic irq_pin_data_out,
   output logic irq_pin_oe_n_out,
   output logic two_wire_enable_out,
   output logic spi_three_wire_out,
   output logic data_line_pullup_out,
   output logic serial_out_pullup_out,
   output logic irq_pin_pulldown_out,
   output logic select_pin_pullup_out
);

   // ---------------- storage ----------------
   logic irq_ref_en_r; // irq-only reference request
   logic sub_ref_en_r; // subtract reference request
   logic latch_r; // latch_request
   logic low_en_r; // low_event_enable
   logic high_en_r; // high_event_enable
   logic [`PTI_DATA_W-1:0] ths_low_r; // threshold bits 7..0
   logic [`PTI_DATA_W-2:0] ths_high_r; // threshold bits 14..8
   logic [`PTI_DATA_W-1:0] if_ctrl_r; // interface_control
   logic [`PTI_DATA_W-2:0] ctrl_one_r; // control_one, bit 7 fixed at zero
   logic [`PTI_REF_W-1:0] ref_r; // captured reference
   pti_mode_t mode_r; // current reference mode
   logic [2:0] src_r; // interrupt source flags
   logic [`PTI_PRESS_W-1:0] press_r; // reported output pressure
   logic [`PTI_DATA_W-1:0] rdata_r; // read data register

   // ---------------- address decode ----------------
   // full seven-bit compare; other addresses store nothing, unmapped ones read zero
   wire logic hit_cfg = (reg_addr_in == `PTI_ADDR_IRQ_CFG);
   wire logic hit_ths_l = (reg_addr_in == `PTI_ADDR_THS_LOW);
   wire logic hit_ths_h = (reg_addr_in == `PTI_ADDR_THS_HIGH);
   wire logic hit_if = (reg_addr_in == `PTI_ADDR_IF_CTRL);
   wire logic hit_ctrl = (reg_addr_in == `PTI_ADDR_CTRL_ONE);
   wire logic hit_src = (reg_addr_in == `PTI_ADDR_IRQ_SRC);

   // write strobes per register
   wire logic wr_cfg = reg_wr_in && hit_cfg;
   wire logic wr_ths_l = reg_wr_in && hit_ths_l;
   wire logic wr_ths_h = reg_wr_in && hit_ths_h;
   wire logic wr_if = reg_wr_in && hit_if;
   wire logic wr_ctrl = reg_wr_in && hit_ctrl;

   // reading the source register releases latched flags
   wire logic rd_src = reg_rd_in && hit_src;

   // reset strobes are one-shot actions and are never stored
   wire logic sub_reset = wr_cfg && reg_wdata_in[`PTI_CFG_SUBREF_RST];
   wire logic irq_reset = wr_cfg && reg_wdata_in[`PTI_CFG_IRQREF_RST];

   // ---------------- arithmetic ----------------
   wire logic [`PTI_THS_W-1:0] ths_val = {ths_high_r, ths_low_r};
   logic signed [`PTI_DIFF_W-1:0] diff_val;
   logic [`PTI_PRESS_W-1:0] press_calc;

   // shared subtract path for both reference modes
   pti_refcalc u_refcalc (
      .meas_in(meas_pressure_in),
      .ref_in(ref_r),
      .mode_in(mode_r),
      .diff_out(diff_val),
      .output_pressure(press_calc)
   );

   // ---------------- capture decisions ----------------
   // a pending request is served by the next conversion; irq-only waits while subtract is pending
   wire logic cap_sub = conv_done_in && sub_ref_en_r;
   wire logic cap_irq = conv_done_in && irq_ref_en_r && !sub_ref_en_r;
   wire logic capture = cap_sub || cap_irq;
   // reference sample in threshold scale
   wire logic [`PTI_REF_W-1:0] meas_hi =
      meas_pressure_in[`PTI_PRESS_W-1:`PTI_PRESS_W-`PTI_REF_W];

   // ---------------- threshold compare ----------------
   // zero extension of the threshold to the difference width
   wire logic signed [`PTI_DIFF_W-1:0] ths_pos = $signed({2'b00, ths_val});
   wire logic signed [`PTI_DIFF_W-1:0] ths_neg = -ths_pos;
   wire logic func_on = high_en_r || low_en_r;
   // the capturing conversion is kept out of the compare, so it raises nothing
   wire logic cmp_ok = conv_done_in && func_on && !capture;
   wire logic evt_high = cmp_ok && high_en_r && (diff_val > ths_pos);
   wire logic evt_low = cmp_ok && low_en_r && (diff_val < ths_neg);
   wire logic [2:0] evt_vec = {evt_high || evt_low, evt_low, evt_high};

   // ---------------- source flag update ----------------
   // latched: flags stay until read; unlatched: each conversion refreshes them.
   // a new event in the cycle of the clearing read survives it
   wire logic src_drop = latch_r ? rd_src : conv_done_in;
   wire logic [2:0] src_nxt = (src_drop ? `PTI_RST_SRC : src_r) | evt_vec;

   // ---------------- mode update ----------------
   pti_mode_t mode_nxt;
   // subtract reset wins over a pending capture in the same cycle; irq reset only once already in irq-only mode
   always_comb begin
      mode_nxt = mode_r;
      if (cap_sub) begin
         mode_nxt = PTI_MODE_SUBTRACT;
      end else if (cap_irq) begin
         mode_nxt = PTI_MODE_IRQ_ONLY;
      end
      if (sub_reset) begin
         mode_nxt = PTI_MODE_NORMAL;
      end else if (irq_reset && mode_r == PTI_MODE_IRQ_ONLY) begin
         mode_nxt = PTI_MODE_NORMAL;
      end
   end

   // reference register: cleared by the subtract reset, loaded on capture
   wire logic [`PTI_REF_W-1:0] ref_nxt =
      sub_reset ? `PTI_RST_REF : (capture ? meas_hi : ref_r);

   // ---------------- request bits ----------------
   // software write wins; otherwise the serving conversion drops the request
   wire logic sub_en_nxt = wr_cfg ? reg_wdata_in[`PTI_CFG_SUBREF_EN] :
                           (cap_sub ? 1'b0 : sub_ref_en_r);
   wire logic irq_en_nxt = wr_cfg ? reg_wdata_in[`PTI_CFG_IRQREF_EN] :
                           (cap_irq ? 1'b0 : irq_ref_en_r);

   // ---------------- read mux ----------------
   logic [`PTI_DATA_W-1:0] rd_mux;
   // reset strobes and unused bits read as zero
   always_comb begin
      case (reg_addr_in)
         `PTI_ADDR_IRQ_CFG: begin
            rd_mux = {irq_ref_en_r, 1'b0, sub_ref_en_r, 1'b0, 1'b0,
                      latch_r, low_en_r, high_en_r};
         end
         `PTI_ADDR_THS_LOW: begin
            rd_mux = ths_low_r;
         end
         `PTI_ADDR_THS_HIGH: begin
            rd_mux = {1'b0, ths_high_r};
         end
         `PTI_ADDR_IF_CTRL: begin
            rd_mux = if_ctrl_r;
         end
         `PTI_ADDR_IDENT: begin
            rd_mux = `PTI_IDENT_VAL;
         end
         `PTI_ADDR_CTRL_ONE: begin
            rd_mux = {1'b0, ctrl_one_r};
         end
         `PTI_ADDR_REF_LOW: begin
            rd_mux = ref_r[7:0];
         end
         `PTI_ADDR_REF_HIGH: begin
            rd_mux = ref_r[15:8];
         end
         `PTI_ADDR_IRQ_SRC: begin
            rd_mux = {5'h00, src_r};
         end
         `PTI_ADDR_OUT_XL: begin
            rd_mux = press_r[7:0];
         end
         `PTI_ADDR_OUT_L: begin
            rd_mux = press_r[15:8];
         end
         `PTI_ADDR_OUT_H: begin
            rd_mux = press_r[23:16];
         end
         default: begin
            // unmapped addresses answer zero
            rd_mux = `PTI_RST_BYTE;
         end
      endcase
   end

   // ---------------- configuration registers ----------------
   // plain stored bits of threshold_irq_config
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         latch_r <= 1'b0;
         low_en_r <= 1'b0;
         high_en_r <= 1'b0;
      end else if (wr_cfg) begin
         latch_r <= reg_wdata_in[`PTI_CFG_LATCH];
         low_en_r <= reg_wdata_in[`PTI_CFG_LOW_EN];
         high_en_r <= reg_wdata_in[`PTI_CFG_HIGH_EN];
      end
   end

   // self-clearing reference requests
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         sub_ref_en_r <= 1'b0;
         irq_ref_en_r <= 1'b0;
      end else begin
         sub_ref_en_r <= sub_en_nxt;
         irq_ref_en_r <= irq_en_nxt;
      end
   end

   // threshold bytes; the top bit of the high byte is not stored
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ths_low_r <= `PTI_RST_BYTE;
         ths_high_r <= `PTI_RST_CTRL;
      end else begin
         if (wr_ths_l) begin
            ths_low_r <= reg_wdata_in;
         end
         if (wr_ths_h) begin
            ths_high_r <= reg_wdata_in[`PTI_DATA_W-2:0];
         end
      end
   end

   // interface_control and control_one; bit 0 of the former reads zero
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         if_ctrl_r <= `PTI_RST_BYTE;
         ctrl_one_r <= `PTI_RST_CTRL;
      end else begin
         if (wr_if) begin
            if_ctrl_r <= {reg_wdata_in[`PTI_DATA_W-1:1], 1'b0};
         end
         if (wr_ctrl) begin
            ctrl_one_r <= reg_wdata_in[`PTI_DATA_W-2:0];
         end
      end
   end

   // ---------------- reference state ----------------
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         mode_r <= PTI_MODE_NORMAL;
         ref_r <= `PTI_RST_REF;
      end else begin
         mode_r <= mode_nxt;
         ref_r <= ref_nxt;
      end
   end

   // ---------------- results ----------------
   // output pressure follows each conversion; subtract capture conversion uses new ref
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         press_r <= `PTI_RST_PRESS;
      end else if (cap_sub) begin
         // subtract mode starts at zero offset from its own sample
         press_r <= meas_pressure_in - {meas_hi, 8'h00};
      end else if (conv_done_in) begin
         press_r <= press_calc;
      end
   end

   // interrupt source flags
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         src_r <= `PTI_RST_SRC;
      end else begin
         src_r <= src_nxt;
      end
   end

   // registered read data, valid the cycle after the read strobe
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rdata_r <= `PTI_RST_BYTE;
      end else if (reg_rd_in) begin
         rdata_r <= rd_mux;
      end
   end

   // ---------------- outputs ----------------
   assign reg_rdata_out = rdata_r;
   assign output_pressure_out = press_r;
   assign threshold_irq_out = src_r[`PTI_SRC_ACTIVE];

   // pin steering from interface_control
   pti_pinctl u_pinctl (
      .if_ctrl_in(if_ctrl_r),
      .i3c_active_in(i3c_active_in),
      .irq_level_in(src_r[`PTI_SRC_ACTIVE]),
      .irq_pin_data_out(irq_pin_data_out),
      .irq_pin_oe_n_out(irq_pin_oe_n_out),
      .two_wire_enable_out(two_wire_enable_out),
      .spi_three_wire_out(spi_three_wire_out),
      .data_line_pullup_out(data_line_pullup_out),
      .serial_out_pullup_out(serial_out_pullup_out),
      .irq_pin_pulldown_out(irq_pin_pulldown_out),
      .select_pin_pullup_out(select_pin_pullup_out)
   );

endmodule

// [dv/pti_regs_properties.sv]
// port-level checks of the pressure threshold register core
// assumes one clock, synchronous active-low reset, accesses taken at the edge
`timescale 1ns/1ps
`include "pti_map.svh"
module pti_regs_chk (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic conv_done_in,
   input wire logic i3c_active_in,
   input wire logic threshold_irq_out,
   input wire logic [23:0] output_pressure_out,
   input wire logic irq_pin_data_out,
   input wire logic irq_pin_oe_n_out,
   input wire logic two_wire_enable_out,
   input wire logic spi_three_wire_out,
   input wire logic data_line_pullup_out,
   input wire logic serial_out_pullup_out,
   input wire logic irq_pin_pulldown_out,
   input wire logic select_pin_pullup_out
);
   logic [7:0] ifc_r; // shadow of interface_control, pins are judged against it
   // the shadow follows host writes, so a decode slip shows as a mismatch
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ifc_r <= 8'h00;
      end else if (reg_wr_in && reg_addr_in == `PTI_ADDR_IF_CTRL) begin
         ifc_r <= reg_wdata_in;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   ident_read_a:
      assert property (reg_rd_in && reg_addr_in == `PTI_ADDR_IDENT |=>
         reg_rdata_out == `PTI_IDENT_VAL) else $error("ident read wrong");
   unmapped_zero_a:
      assert property (reg_rd_in && reg_addr_in < 7'h0B |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   ths_top_a:
      assert property (reg_rd_in && reg_addr_in == `PTI_ADDR_THS_HIGH |=> !reg_rdata_out[7])
      else $error("threshold top bit set");
   pin_follow_a:
      assert property (irq_pin_data_out == threshold_irq_out) else $error("pin data off");
   irq_cause_a:
      assert property ($changed(threshold_irq_out) |-> $past(conv_done_in) || $past(reg_rd_in))
      else $error("irq moved without cause");
   out_hold_a:
      assert property (!conv_done_in |=> $stable(output_pressure_out))
      else $error("pressure moved without conversion");
   pin_oe_a:
      assert property (irq_pin_oe_n_out == (i3c_active_in && !ifc_r[7]))
      else $error("irq pin enable wrong");
   bus_off_a:
      assert property (two_wire_enable_out == !ifc_r[6]) else $error("two-wire enable wrong");
   spi_form_a:
      assert property (spi_three_wire_out == ifc_r[5]) else $error("spi form wrong");
   pull_ctl_a:
      assert property ({data_line_pullup_out, serial_out_pullup_out, irq_pin_pulldown_out,
         select_pin_pullup_out} == {ifc_r[4], ifc_r[3], !ifc_r[2], !ifc_r[1]})
      else $error("pull controls wrong");
   cover property (conv_done_in ##1 $rose(threshold_irq_out));
   cover property (reg_rd_in && reg_addr_in == `PTI_ADDR_IRQ_SRC ##1 $fell(threshold_irq_out));
   cover property (!irq_pin_oe_n_out);
endmodule
bind pti_regs pti_regs_chk pti_regs_chk_i (.clock_in, .rstn_in, .reg_addr_in, .reg_wr_in,
   .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .conv_done_in, .i3c_active_in,
   .threshold_irq_out, .output_pressure_out, .irq_pin_data_out, .irq_pin_oe_n_out,
   .two_wire_enable_out, .spi_three_wire_out, .data_line_pullup_out,
   .serial_out_pullup_out, .irq_pin_pulldown_out, .select_pin_pullup_out);

// [dv/pti_host_model.sv]
// host side model: issues single-byte register accesses to the core
// assumes answer one edge after the read strobe, as the core hands over
`timescale 1ns/1ps
module pti_host_model (
   input wire logic clock_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [6:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out
);
   // idle bus at time zero
   initial begin
      reg_addr_out = 7'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   // one write: seven-bit address and data held over exactly one taking edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock_in);
      #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(posedge clock_in);
      #1;
      reg_wr_out = 1'b0;
      reg_addr_out = ~a; // released lines never keep the old value
      reg_wdata_out = ~d;
   endtask
   // one read: data picked up once the taking edge has landed
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clock_in);
      #1;
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(posedge clock_in);
      #1;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
   endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench of the pressure threshold core against an integer model
// assumes the host model for accesses; conversions are driven from here
`timescale 1ns/1ps
`include "pti_map.svh"
module tb_top;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [6:0] reg_addr_in;
   logic reg_wr_in, reg_rd_in;
   logic [7:0] reg_wdata_in, reg_rdata_out;
   logic conv_done_in = 1'b0;
   logic [23:0] meas_pressure_in = 24'h000000;
   logic i3c_active_in = 1'b0;
   logic threshold_irq_out, irq_pin_data_out, irq_pin_oe_n_out, two_wire_enable_out;
   logic spi_three_wire_out, data_line_pullup_out, serial_out_pullup_out;
   logic irq_pin_pulldown_out, select_pin_pullup_out;
   logic [23:0] output_pressure_out;
   int n_fail = 0; // mismatches
   int checked = 0; // comparisons
   integer seed = 32'hC8228CE6;
   int m_cfg, m_ths, m_ref, m_mode, m_src, m_out, m_ifc, m_c1; // model state
   int ro[4] = '{'h0F, 'h16, 'h24, 'h2A}; // read-only places
   int rw[3] = '{'h0C, 'h0D, 'h10}; // plain writable bytes
   int cap_rd[3] = '{'h0B, 'h16, 'h17}; // config and reference bytes
   always #5 clock_in = ~clock_in;
   pti_regs pti_regs_i (.clock_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
      .reg_wdata_in, .reg_rdata_out, .conv_done_in, .meas_pressure_in, .i3c_active_in,
      .threshold_irq_out, .output_pressure_out, .irq_pin_data_out, .irq_pin_oe_n_out,
      .two_wire_enable_out, .spi_three_wire_out, .data_line_pullup_out,
      .serial_out_pullup_out, .irq_pin_pulldown_out, .select_pin_pullup_out);
   pti_host_model pti_host_model_i (.clock_in, .reg_rdata_in(reg_rdata_out),
      .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
      .reg_wdata_out(reg_wdata_in));
   function automatic int rnd();
      return $random(seed);
   endfunction
   // sample whose upper word sits close to the reference, so both events occur
   function automatic int near();
      return (((m_ref + rnd() % 64) & 'hFFFF) << 8) | (rnd() & 'hFF);
   endfunction
   // model view of a register read
   function automatic int exp_rd(input int a);
      case (a)
         'h0B: return m_cfg;
         'h0C: return m_ths & 'hFF;
         'h0D: return m_ths >> 8;
         'h0E: return m_ifc;
         'h0F: return `PTI_IDENT_VAL;
         'h10: return m_c1;
         'h16: return m_ref & 'hFF;
         'h17: return m_ref >> 8;
         'h24: return m_src;
         'h28: return m_out & 'hFF;
         'h29: return (m_out >> 8) & 'hFF;
         'h2A: return m_out >> 16;
         default: return 0;
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input int exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // reset held ten cycles, model cleared alongside
   task automatic rst_all();
      rstn_in = 1'b0;
      repeat (10) @(posedge clock_in);
      #1;
      rstn_in = 1'b1;
      {m_cfg, m_ths, m_ref, m_mode, m_src, m_out, m_ifc, m_c1} = '0;
   endtask
   task automatic rd_chk(input int a);
      logic [7:0] d;
      int e;
      e = exp_rd(a);
      pti_host_model_i.rd(a[6:0], d);
      if (a == 'h24 && m_cfg[2]) begin
         m_src = 0; // latched source empties on read
      end
      check($sformatf("reg %0h", a), {24'h0, d}, e);
   endtask
   // write plus model side effects; reset bits act as strobes
   task automatic wr_m(input int a, input int d);
      pti_host_model_i.wr(a[6:0], d[7:0]);
      case (a)
         'h0B: begin
            if (d[4]) begin
               m_mode = 0;
               m_ref = 0;
            end
            if (d[6] && m_mode == 2) begin
               m_mode = 0;
            end
            m_cfg = d & 'hA7;
         end
         'h0C: m_ths = (m_ths & 'h7F00) | (d & 'hFF);
         'h0D: m_ths = (m_ths & 'hFF) | ((d & 'h7F) << 8);
         'h0E: m_ifc = d & 'hFE;
         'h10: m_c1 = d & 'h7F;
         default: ;
      endcase
   endtask
   task automatic pins();
      check("oe_n", {31'h0, irq_pin_oe_n_out}, i3c_active_in & !m_ifc[7]);
      check("two_wire", {31'h0, two_wire_enable_out}, !m_ifc[6]);
      check("spi3", {31'h0, spi_three_wire_out}, m_ifc[5]);
      check("pulls", {28'h0, data_line_pullup_out, serial_out_pullup_out,
         irq_pin_pulldown_out, select_pin_pullup_out}, {m_ifc[4:3], !m_ifc[2], !m_ifc[1]});
   endtask
   // one conversion strobe, then model and design compared
   task automatic conv(input int m);
      int d;
      bit cap;
      bit hi;
      bit lo;
      @(posedge clock_in);
      #1;
      conv_done_in = 1'b1;
      meas_pressure_in = m[23:0];
      @(posedge clock_in);
      #1;
      conv_done_in = 1'b0;
      meas_pressure_in = ~m[23:0]; // stale sample must not leak in
      cap = m_cfg[5] | m_cfg[7];
      if (cap) begin
         m_ref = (m >> 8) & 'hFFFF;
         m_mode = m_cfg[5] ? 1 : 2;
         m_cfg = m_cfg & (m_cfg[5] ? 'hDF : 'h7F);
      end
      m_out = (m_mode == 1 ? m - (m_ref << 8) : m) & 'hFFFFFF;
      d = ((m >> 8) & 'hFFFF) - (m_mode != 0 ? m_ref : 0);
      // the capturing conversion raises no event, yet unlatched flags still refresh on it
      hi = !cap && m_cfg[0] && d > m_ths;
      lo = !cap && m_cfg[1] && d < -m_ths;
      m_src = (m_cfg[2] ? m_src : 0) | {hi | lo, lo, hi};
      check("irq", {31'h0, threshold_irq_out}, m_src >> 2);
      check("press", {8'h00, output_pressure_out}, m_out);
   endtask
   initial begin
      repeat (100000) @(posedge clock_in);
      n_fail++;
      print_verdict();
   end
   initial begin
      rst_all();
      for (int a = 'h0A; a <= 'h2A; a++) begin
         rd_chk(a);
      end
      foreach (ro[i]) begin
         wr_m(ro[i], 'hFF);
         rd_chk(ro[i]);
      end
      repeat (4) begin
         foreach (rw[i]) begin
            wr_m(rw[i], rnd());
            rd_chk(rw[i]);
         end
      end
      repeat (8) begin
         wr_m('h0E, rnd());
         i3c_active_in = 1'(rnd());
         #1;
         pins();
         rd_chk('h0E);
      end
      wr_m('h0C, 2 * 16);
      wr_m('h0D, 0);
      wr_m('h0B, 'h23);
      conv(rnd());
      foreach (cap_rd[i]) begin
         rd_chk(cap_rd[i]);
      end
      repeat (6) begin
         conv(near());
         rd_chk('h2A);
      end
      wr_m('h0B, 'h13);
      conv(rnd());
      foreach (cap_rd[i]) begin
         rd_chk(cap_rd[i]);
      end
      wr_m('h0B, 'h83);
      conv(rnd());
      rd_chk('h0B);
      repeat (12) begin
         wr_m('h0B, rnd() & 7);
         conv(near());
         conv(near());
         rd_chk('h24);
      end
      wr_m('h0B, 'h43);
      conv(near());
      rst_all();
      pins();
      foreach (cap_rd[i]) begin
         rd_chk(cap_rd[i]);
      end
      print_verdict();
   end
endmodule
